/* File: common/dsu_pkg.sv */
// constants, register map and field layout of the dual serial unit
package dsu_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] BLOCK_BASE = 12'h700;
  localparam logic [11:0] BLOCK_MASK = 12'hfc0;
  localparam logic [11:0] OFF_CFG_HI = 12'h700;
  localparam logic [11:0] OFF_CFG_LO = 12'h701;
  localparam logic [11:0] OFF_LEVEL = 12'h704;
  localparam logic [11:0] OFF_VECTOR = 12'h705;
  localparam logic [11:0] OFF_MODE_A = 12'h710;
  localparam logic [11:0] OFF_STAT_A = 12'h711;
  localparam logic [11:0] OFF_MODE_B = 12'h718;
  localparam logic [11:0] OFF_STAT_B = 12'h719;
  localparam logic [11:0] SUPER_ONLY_END = 12'h70f;
  // configuration register fields
  localparam int CFG_STOP = 15;
  localparam int CFG_FRZ_HI = 14;
  localparam int CFG_FRZ_LO = 13;
  localparam int CFG_CTSCLK = 12;
  localparam int CFG_SUPERVISOR_ONLY_BIT = 7;
  localparam int CFG_ARB_HI = 3;
  localparam logic [15:0] CFG_WMASK = 16'hf08f;
  localparam logic [15:0] CFG_RESET = 16'h0080;
  localparam logic [7:0] LEVEL_WMASK = 8'h07;
  localparam logic [7:0] LEVEL_RESET = 8'h00;
  localparam logic [7:0] VECTOR_RESET = 8'h0f;
  // channel mode one fields
  localparam int MR_RXFLOW = 7;
  localparam int MR_RDYSEL = 6;
  localparam int MR_ERRMODE = 5;
  localparam int MR_PM_HI = 4;
  localparam int MR_PM_LO = 3;
  localparam int MR_PTYPE = 2;
  localparam int MR_LEN_HI = 1;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [1:0] PM_WITH = 2'h0;
  localparam logic [1:0] PM_FORCE = 2'h1;
  localparam logic [1:0] PM_NONE = 2'h2;
  localparam logic [1:0] PM_MULTI = 2'h3;
  localparam logic [3:0] ARB_OFF = 4'h0;
  localparam logic [2:0] LEVEL_NONE = 3'h0;
  typedef enum {REG_CFG_HI, REG_CFG_LO, REG_LEVEL, REG_VECTOR, REG_MODE_A,
    REG_STAT_A, REG_MODE_B, REG_STAT_B, REG_RSVD} dsu_reg_type;
endpackage : dsu_pkg

/* File: rtl/dsu_chan_stat.sv */
// per channel request-to-send, ready select and error status
`timescale 1ns/100ps
module dsu_chan_stat (
  input wire logic mclk,
  input wire logic clrN,
  input wire logic rxFlowEn,
  input wire logic txFlowEn,
  input wire logic portBit,
  input wire logic startBit,
  input wire logic fifoFull,
  input wire logic readySel,
  input wire logic errMode,
  input wire logic rxLoad,
  input wire logic bufRead,
  input wire logic fifoEmpty,
  input wire logic topLoad,
  input wire logic [2:0] topErr,
  input wire logic errReset,
  output logic rtsOn_q,
  output logic txFlowOk_q,
  output logic isrRx_q,
  output logic [2:0] errStat_q
);
  logic badCombo;
  assign badCombo = rxFlowEn & txFlowEn;

  always_ff @(posedge mclk) begin
    if (!clrN) begin
      rtsOn_q <= 1'b0;
    end else if (!rxFlowEn || badCombo) begin
      rtsOn_q <= portBit;
    end else if (startBit && fifoFull) begin
      rtsOn_q <= 1'b0;
    end else if (!fifoFull) begin
      rtsOn_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!clrN) begin
      txFlowOk_q <= 1'b0;
    end else begin
      txFlowOk_q <= txFlowEn & ~badCombo;
    end
  end

  always_ff @(posedge mclk) begin
    if (!clrN) begin
      isrRx_q <= 1'b0;
    end else if (readySel) begin
      isrRx_q <= fifoFull;
    end else if (rxLoad) begin
      isrRx_q <= 1'b1;
    end else if (bufRead && fifoEmpty) begin
      isrRx_q <= 1'b0;
    end
  end

  // accumulation: a reset with a new top character clears the old bits but keeps the new character's errors
  always_ff @(posedge mclk) begin
    if (!clrN) begin
      errStat_q <= 3'h0;
    end else if (!errMode) begin
      errStat_q <= topErr;
    end else if (topLoad) begin
      errStat_q <= (errReset ? 3'h0 : errStat_q) | topErr;
    end else if (errReset) begin
      errStat_q <= 3'h0;
    end
  end
endmodule : dsu_chan_stat

/* File: rtl/dsu_config.sv */
// configuration, privilege, freeze, interrupt and mode control of the dual serial unit
`timescale 1ns/100ps
module dsu_config
  import dsu_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic swReset,
  input wire logic busStrobe,
  input wire logic busRead,
  input wire logic busSuper,
  input wire logic [11:0] busAddr,
  input wire logic [7:0] busWdata,
  output logic busAck_q,
  output logic busErr_q,
  output logic [7:0] busRdata_q,
  input wire logic freezeReq,
  input wire logic [1:0] charBoundary,
  input wire logic [1:0] sendingBreak,
  output logic [1:0] chanFrozen_q,
  output logic modClkRun_q,
  output logic ctsClkExt_q,
  input wire logic irqPending,
  input wire logic iackCycle,
  input wire logic [2:0] iackLevel,
  output logic [2:0] irqLevel_q,
  output logic [3:0] arbPriority_q,
  output logic iackWin_q,
  output logic [7:0] iackVector_q,
  input wire logic [1:0] txFlowEn,
  input wire logic [1:0] portBit,
  input wire logic [1:0] startBit,
  input wire logic [1:0] fifoFull,
  input wire logic [1:0] fifoEmpty,
  input wire logic [1:0] rxLoad,
  input wire logic [1:0] bufRead,
  input wire logic [1:0] topLoad,
  input wire logic [5:0] topErr,
  input wire logic [1:0] errReset,
  input wire logic [4:0] otherStat [2],
  input wire logic [7:0] txData [2],
  input wire logic [7:0] rxData [2],
  input wire logic [1:0] rxParIn,
  output logic [1:0] rtsOn_q,
  output logic [1:0] txFlowOk_q,
  output logic [1:0] isrRx_q,
  output logic [1:0] txParBit_q,
  output logic [1:0] txParUsed_q,
  output logic [1:0] rxParErr_q
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode, shared by the read and the write path

  function automatic dsu_reg_type decodeReg(input logic [11:0] a);
    case (a)
      OFF_CFG_HI: decodeReg = REG_CFG_HI;
      OFF_CFG_LO: decodeReg = REG_CFG_LO;
      OFF_LEVEL: decodeReg = REG_LEVEL;
      OFF_VECTOR: decodeReg = REG_VECTOR;
      OFF_MODE_A: decodeReg = REG_MODE_A;
      OFF_STAT_A: decodeReg = REG_STAT_A;
      OFF_MODE_B: decodeReg = REG_MODE_B;
      OFF_STAT_B: decodeReg = REG_STAT_B;
      default: decodeReg = REG_RSVD;
    endcase
  endfunction : decodeReg

  logic [15:0] cfg_q;
  logic [7:0] level_q;
  logic [7:0] vector_q;
  logic [7:0] mode_q [2];
  logic [2:0] errStat [2];
  logic clrN;
  logic hit;
  logic stopped;
  logic isCfg;
  logic superOnly;
  logic denied;
  logic wrOk;
  dsu_reg_type regSel;

  assign clrN = rst_n & ~swReset;
  assign stopped = cfg_q[CFG_STOP];
  assign hit = busStrobe && ((busAddr & BLOCK_MASK) == BLOCK_BASE);
  assign regSel = decodeReg(busAddr);
  assign isCfg = (regSel == REG_CFG_HI) || (regSel == REG_CFG_LO);
  assign superOnly = (busAddr <= SUPER_ONLY_END) || cfg_q[CFG_SUPERVISOR_ONLY_BIT];

  always_comb begin
    denied = 1'b0;
    if (stopped && !isCfg) begin
      denied = 1'b1;
    end else if (superOnly && !busSuper) begin
      denied = 1'b1;
    end
  end

  assign wrOk = hit && !busRead && !denied;

  ////////////////////////////////////////////////////////////////////////////
  // bus answer: one cycle after the strobe, no wait states

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      busAck_q <= 1'b0;
      busErr_q <= 1'b0;
    end else begin
      busAck_q <= hit && !denied;
      busErr_q <= hit && denied;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      busRdata_q <= 8'h00;
    end else if (hit && busRead && !denied) begin
      case (regSel)
        REG_CFG_HI: busRdata_q <= cfg_q[15:8];
        REG_CFG_LO: busRdata_q <= cfg_q[7:0];
        REG_LEVEL: busRdata_q <= level_q;
        REG_VECTOR: busRdata_q <= vector_q;
        REG_MODE_A: busRdata_q <= mode_q[0];
        REG_STAT_A: busRdata_q <= {errStat[0], otherStat[0]};
        REG_MODE_B: busRdata_q <= mode_q[1];
        REG_STAT_B: busRdata_q <= {errStat[1], otherStat[1]};
        default: busRdata_q <= 8'h00;
      endcase
    end else begin
      busRdata_q <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration register: only hardware reset clears it

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cfg_q <= CFG_RESET;
    end else if (wrOk && regSel == REG_CFG_HI) begin
      cfg_q[15:8] <= busWdata & CFG_WMASK[15:8];
    end else if (wrOk && regSel == REG_CFG_LO) begin
      cfg_q[7:0] <= busWdata & CFG_WMASK[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!clrN) begin
      level_q <= LEVEL_RESET;
    end else if (wrOk && regSel == REG_LEVEL) begin
      level_q <= busWdata & LEVEL_WMASK;
    end
  end

  always_ff @(posedge mclk) begin
    if (!clrN) begin
      vector_q <= VECTOR_RESET;
    end else if (wrOk && regSel == REG_VECTOR) begin
      vector_q <= busWdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!clrN) begin
      mode_q[0] <= MODE_RESET;
      mode_q[1] <= MODE_RESET;
    end else if (wrOk && regSel == REG_MODE_A) begin
      mode_q[0] <= busWdata;
    end else if (wrOk && regSel == REG_MODE_B) begin
      mode_q[1] <= busWdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock stop and capture clock choice
  // the gate cell downstream latches the enable in the low phase, so clocks
  // stop low; the bus side of this block keeps running to reach cfg_q

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      modClkRun_q <= 1'b1;
      ctsClkExt_q <= 1'b0;
    end else begin
      modClkRun_q <= ~cfg_q[CFG_STOP];
      ctsClkExt_q <= cfg_q[CFG_CTSCLK];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // freeze: each channel waits for its own character boundary

  logic freezeOn;
  assign freezeOn = freezeReq && cfg_q[CFG_FRZ_HI];

  always_ff @(posedge mclk) begin
    if (!clrN) begin
      chanFrozen_q <= 2'h0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (!freezeOn) begin
          chanFrozen_q[c] <= 1'b0;
        end else if (charBoundary[c] && !sendingBreak[c]) begin
          chanFrozen_q[c] <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt request level, arbitration and vector

  always_ff @(posedge mclk) begin
    if (!clrN) begin
      irqLevel_q <= LEVEL_NONE;
      arbPriority_q <= ARB_OFF;
    end else begin
      irqLevel_q <= (irqPending && !stopped) ? level_q[2:0] : LEVEL_NONE;
      arbPriority_q <= cfg_q[CFG_ARB_HI:0];
    end
  end

  // a stopped module or zero priority never answers an acknowledge
  always_ff @(posedge mclk) begin
    if (!clrN) begin
      iackWin_q <= 1'b0;
      iackVector_q <= 8'h00;
    end else if (iackCycle && irqPending && !stopped && level_q[2:0] != LEVEL_NONE
                 && iackLevel == level_q[2:0] && cfg_q[CFG_ARB_HI:0] != ARB_OFF) begin
      iackWin_q <= 1'b1;
      iackVector_q <= vector_q;
    end else begin
      iackWin_q <= 1'b0;
      iackVector_q <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per channel flow control, status and parity

  generate
    for (genvar c = 0; c < 2; c++) begin : gChan
      logic txPar;
      logic txUsed;
      logic rxPar;
      logic rxUsed;

      dsu_chan_stat uStat (
        .mclk(mclk),
        .clrN(clrN),
        .rxFlowEn(mode_q[c][MR_RXFLOW]),
        .txFlowEn(txFlowEn[c]),
        .portBit(portBit[c]),
        .startBit(startBit[c] & modClkRun_q),
        .fifoFull(fifoFull[c]),
        .readySel(mode_q[c][MR_RDYSEL]),
        .errMode(mode_q[c][MR_ERRMODE]),
        .rxLoad(rxLoad[c]),
        .bufRead(bufRead[c]),
        .fifoEmpty(fifoEmpty[c]),
        .topLoad(topLoad[c]),
        .topErr(topErr[3*c+2:3*c]),
        .errReset(errReset[c]),
        .rtsOn_q(rtsOn_q[c]),
        .txFlowOk_q(txFlowOk_q[c]),
        .isrRx_q(isrRx_q[c]),
        .errStat_q(errStat[c])
      );

      dsu_parity uTxPar (
        .data(txData[c]),
        .charLen(mode_q[c][MR_LEN_HI:0]),
        .parMode(mode_q[c][MR_PM_HI:MR_PM_LO]),
        .parType(mode_q[c][MR_PTYPE]),
        .parBit(txPar),
        .parUsed(txUsed)
      );

      // receive check uses the same generator; type bit selects odd/even
      dsu_parity uRxPar (
        .data(rxData[c]),
        .charLen(mode_q[c][MR_LEN_HI:0]),
        .parMode(mode_q[c][MR_PM_HI:MR_PM_LO]),
        .parType(mode_q[c][MR_PTYPE]),
        .parBit(rxPar),
        .parUsed(rxUsed)
      );

      // multidrop carries the address flag instead of a checked parity
      always_ff @(posedge mclk) begin
        if (!clrN) begin
          txParBit_q[c] <= 1'b0;
          txParUsed_q[c] <= 1'b0;
          rxParErr_q[c] <= 1'b0;
        end else begin
          txParBit_q[c] <= txPar;
          txParUsed_q[c] <= txUsed;
          if (mode_q[c][MR_PM_HI:MR_PM_LO] == PM_MULTI) begin
            rxParErr_q[c] <= rxParIn[c];
          end else begin
            rxParErr_q[c] <= rxUsed && (rxPar != rxParIn[c]);
          end
        end
      end
    end
  endgenerate

endmodule : dsu_config

/* File: rtl/dsu_parity.sv */
// parity bit for one character under the programmed framing
`timescale 1ns/100ps
module dsu_parity
  import dsu_pkg::*;
(
  input wire logic [7:0] data,
  input wire logic [1:0] charLen,
  input wire logic [1:0] parMode,
  input wire logic parType,
  output logic parBit,
  output logic parUsed
);
  logic [7:0] lenMask;
  always_comb begin
    lenMask = 8'hff >> (3'h3 - {1'b0, charLen});
    parUsed = (parMode != PM_NONE);
    case (parMode)
      PM_WITH: parBit = (^(data & lenMask)) ^ parType;
      PM_FORCE: parBit = parType;
      PM_MULTI: parBit = parType;
      default: parBit = 1'b0;
    endcase
  end
endmodule : dsu_parity

/* File: test/dsu_config_asserts.sv */
// concurrent checks on the register bus, freeze and acknowledge ports of the serial unit
`timescale 1ns/100ps
module dsu_config_asserts (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic busStrobe,
  input wire logic busSuper,
  input wire logic [11:0] busAddr,
  input wire logic busAck_q,
  input wire logic busErr_q,
  input wire logic [7:0] busRdata_q,
  input wire logic freezeReq,
  input wire logic [1:0] charBoundary,
  input wire logic [1:0] sendingBreak,
  input wire logic [1:0] chanFrozen_q,
  input wire logic modClkRun_q,
  input wire logic irqPending,
  input wire logic iackCycle,
  input wire logic [3:0] arbPriority_q,
  input wire logic iackWin_q
);
  logic inBlk;
  logic cfgAddr;
  assign inBlk = busAddr[11:6] == 6'h1c;
  assign cfgAddr = busAddr[11:1] == 11'h380;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  a_answer_once: assert property (busStrobe && inBlk |=> busAck_q != busErr_q)
    else $error("block access not answered once");
  a_outside_quiet: assert property (busStrobe && !inBlk |=> !busAck_q && !busErr_q)
    else $error("answer to address outside block");
  // the run flag lags the stop bit by one cycle, so it is looked at one cycle after the strobe
  a_stop_refuse: assert property (busStrobe && inBlk && !cfgAddr ##1 !modClkRun_q
    |-> busErr_q)
    else $error("access while stopped not refused");
  a_stop_cfg_ok: assert property (!modClkRun_q && busStrobe && busSuper && cfgAddr |=> busAck_q)
    else $error("config access while stopped refused");
  a_user_refused: assert property (busStrobe && !busSuper && busAddr[11:4] == 8'h70
    |=> busErr_q && !busAck_q)
    else $error("user access to supervisor register accepted");
  a_rdata_idle: assert property (!busAck_q |-> busRdata_q == 8'h00)
    else $error("read data without ack");
  a_freeze_cause: assert property ($rose(chanFrozen_q[0])
    |-> $past(freezeReq && charBoundary[0] && !sendingBreak[0]))
    else $error("channel froze without cause");
  a_freeze_drop: assert property (!freezeReq |=> chanFrozen_q == 2'b00)
    else $error("frozen after freeze dropped");
  a_break_run: assert property (sendingBreak[1] && !chanFrozen_q[1] |=> !chanFrozen_q[1])
    else $error("break sender froze");
  a_iack_cause: assert property (iackWin_q |-> $past(iackCycle && irqPending)
    && arbPriority_q != 4'h0)
    else $error("acknowledge won without cause");
endmodule : dsu_config_asserts

/* File: test/dsu_remote_stn.sv */
// remote serial station: starts a character only while its clear-to-send input is high
`timescale 1ns/100ps
module dsu_remote_stn (
  input wire logic mclk,
  input wire logic ctsIn,
  input wire logic go,
  output logic startBit_q
);
  // a go pulse while our request-to-send is negated starts no character and is not kept
  always_ff @(posedge mclk) begin
    startBit_q <= go & ctsIn;
  end
endmodule : dsu_remote_stn

/* File: test/tb.sv */
// self-checking bench for the serial unit configuration and mode block
`timescale 1ns/100ps
module tb;
  import dsu_pkg::*;
  logic mclk, rst_n = 1'b0, swReset = 1'b0, busStrobe = 1'b0, busRead = 1'b0;
  logic busSuper = 1'b0, freezeReq = 1'b0, irqPending = 1'b0, iackCycle = 1'b0, stnGo = 1'b0;
  logic [11:0] busAddr = 12'h000;
  logic [7:0] busWdata = 8'h00, busRdata_q, iackVector_q;
  logic busAck_q, busErr_q, modClkRun_q, ctsClkExt_q, iackWin_q, stnStart;
  logic [7:0] lastRd = 8'h00;
  logic [1:0] charBoundary = 2'h0, sendingBreak = 2'h0, txFlowEn = 2'h0, portBit = 2'h0;
  logic [1:0] fifoFull = 2'h0, fifoEmpty = 2'h0, rxLoad = 2'h0, bufRead = 2'h0;
  logic [1:0] topLoad = 2'h0, errReset = 2'h0, rxParIn = 2'h0;
  logic [1:0] chanFrozen_q, rtsOn_q, txFlowOk_q, isrRx_q, txParBit_q, txParUsed_q, rxParErr_q;
  logic [2:0] iackLevel = 3'h0, irqLevel_q;
  logic [3:0] arbPriority_q;
  logic [5:0] topErr = 6'h00;
  logic [4:0] otherStat [2] = '{5'h00, 5'h00};
  logic [7:0] txData [2] = '{8'he1, 8'h00}, rxData [2] = '{8'he1, 8'h00};
  // mode byte and expected {parity used, parity bit} for data e1
  localparam logic [7:0] PM_TAB [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h07, 8'h0b, 8'h0f,
    8'h13, 8'h1b, 8'h1f};
  localparam logic [1:0] PE_TAB [10] = '{2'h3, 2'h2, 2'h3, 2'h2, 2'h3, 2'h2, 2'h3, 2'h0,
    2'h2, 2'h3};
  int fails = 0, checks = 0, cyc = 0;

  dsu_config DUT (.mclk(mclk), .rst_n(rst_n), .swReset(swReset), .busStrobe(busStrobe),
    .busRead(busRead), .busSuper(busSuper), .busAddr(busAddr), .busWdata(busWdata),
    .busAck_q(busAck_q), .busErr_q(busErr_q), .busRdata_q(busRdata_q),
    .freezeReq(freezeReq), .charBoundary(charBoundary), .sendingBreak(sendingBreak),
    .chanFrozen_q(chanFrozen_q), .modClkRun_q(modClkRun_q), .ctsClkExt_q(ctsClkExt_q),
    .irqPending(irqPending), .iackCycle(iackCycle), .iackLevel(iackLevel),
    .irqLevel_q(irqLevel_q), .arbPriority_q(arbPriority_q), .iackWin_q(iackWin_q),
    .iackVector_q(iackVector_q), .txFlowEn(txFlowEn), .portBit(portBit),
    .startBit({1'b0, stnStart}), .fifoFull(fifoFull), .fifoEmpty(fifoEmpty),
    .rxLoad(rxLoad), .bufRead(bufRead), .topLoad(topLoad), .topErr(topErr),
    .errReset(errReset), .otherStat(otherStat), .txData(txData), .rxData(rxData),
    .rxParIn(rxParIn), .rtsOn_q(rtsOn_q), .txFlowOk_q(txFlowOk_q), .isrRx_q(isrRx_q),
    .txParBit_q(txParBit_q), .txParUsed_q(txParUsed_q), .rxParErr_q(rxParErr_q));

  dsu_remote_stn u_stn (.mclk(mclk), .ctsIn(rtsOn_q[0]), .go(stnGo), .startBit_q(stnStart));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // whole run is under two hundred cycles; the ceiling only catches a hang
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      wrap_up();
    end
  end
  ////////////////////////////////////////
  task chk(input logic [7:0] s, e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, s, e);
    end
  endtask : chk

  // entered at a falling edge; strobe lasts one cycle, the answer is taken just after it is lowered,
  // then an idle cycle keeps the strobe from being lowered and raised in one time step
  task acc(input logic rd, sup, input logic [11:0] a, input logic [7:0] d, input logic [1:0] an);
    busStrobe = 1'b1;
    busRead = rd;
    busSuper = sup;
    busAddr = a;
    busWdata = d;
    @(negedge mclk);
    busStrobe = 1'b0;
    lastRd = busRdata_q;
    chk({6'h0, busErr_q, busAck_q}, {6'h0, an});
    @(negedge mclk);
  endtask : acc

  task wr(input logic [11:0] a, input logic [7:0] d);
    acc(1'b0, 1'b1, a, d, 2'b01);
  endtask : wr

  task rd(input logic [11:0] a, input logic [7:0] e);
    acc(1'b1, 1'b1, a, 8'h00, 2'b01);
    chk(lastRd, e);
  endtask : rd

  task tick(input int n);
    repeat (n) @(negedge mclk);
  endtask : tick
  ////////////////////////////////////////
  task t_regs;
    rd(OFF_CFG_HI, 8'h00);
    rd(OFF_CFG_LO, CFG_RESET[7:0]);
    rd(OFF_LEVEL, LEVEL_RESET);
    rd(OFF_VECTOR, 8'h0f);
    rd(OFF_MODE_B, 8'h00);
    rd(12'h702, 8'h00);
    acc(1'b1, 1'b1, 12'h740, 8'h00, 2'b00);
    wr(OFF_LEVEL, 8'hff);
    rd(OFF_LEVEL, 8'h07);
    wr(OFF_CFG_LO, 8'hff);
    rd(OFF_CFG_LO, 8'h8f);
    wr(OFF_STAT_A, 8'hff);
    rd(OFF_STAT_A, 8'h00);
    wr(OFF_CFG_LO, 8'h80);
    wr(OFF_LEVEL, 8'h00);
    $display("t_regs done");
  endtask : t_regs

  task t_priv;
    acc(1'b1, 1'b0, OFF_VECTOR, 8'h00, 2'b10);
    acc(1'b0, 1'b0, OFF_CFG_HI, 8'h80, 2'b10);
    chk({7'h0, modClkRun_q}, 8'h01);
    acc(1'b1, 1'b0, OFF_MODE_B, 8'h00, 2'b10);
    wr(OFF_CFG_LO, 8'h00);
    acc(1'b1, 1'b0, OFF_MODE_B, 8'h00, 2'b01);
    acc(1'b1, 1'b0, OFF_LEVEL, 8'h00, 2'b10);
    wr(OFF_CFG_LO, 8'h80);
    $display("t_priv done");
  endtask : t_priv

  task t_stop;
    wr(OFF_CFG_HI, 8'h80);
    tick(1);
    chk({7'h0, modClkRun_q}, 8'h00);
    acc(1'b1, 1'b1, OFF_LEVEL, 8'h00, 2'b10);
    acc(1'b0, 1'b1, OFF_MODE_A, 8'h55, 2'b10);
    rd(OFF_CFG_HI, 8'h80);
    wr(OFF_CFG_HI, 8'h00);
    tick(2);
    chk({7'h0, modClkRun_q}, 8'h01);
    rd(OFF_MODE_A, 8'h00);
    $display("t_stop done");
  endtask : t_stop

  task t_swrst;
    wr(OFF_VECTOR, 8'h42);
    wr(OFF_MODE_A, 8'h1f);
    wr(OFF_CFG_HI, 8'h10);
    swReset = 1'b1;
    tick(1);
    swReset = 1'b0;
    chk({7'h0, ctsClkExt_q}, 8'h01);
    rd(OFF_VECTOR, VECTOR_RESET);
    rd(OFF_MODE_A, MODE_RESET);
    rd(OFF_CFG_HI, 8'h10);
    wr(OFF_CFG_HI, 8'h00);
    tick(1);
    chk({7'h0, ctsClkExt_q}, 8'h00);
    $display("t_swrst done");
  endtask : t_swrst

  task t_freeze;
    charBoundary = 2'b11;
    freezeReq = 1'b1;
    wr(OFF_CFG_HI, 8'h20);
    tick(2);
    chk({6'h0, chanFrozen_q}, 8'h00);
    sendingBreak = 2'b10;
    wr(OFF_CFG_HI, 8'h60);
    tick(2);
    chk({6'h0, chanFrozen_q}, 8'h01);
    freezeReq = 1'b0;
    tick(1);
    chk({6'h0, chanFrozen_q}, 8'h00);
    sendingBreak = 2'b00;
    charBoundary = 2'b10;
    wr(OFF_CFG_HI, 8'h40);
    freezeReq = 1'b1;
    tick(2);
    chk({6'h0, chanFrozen_q}, 8'h02);
    freezeReq = 1'b0;
    charBoundary = 2'b00;
    wr(OFF_CFG_HI, 8'h00);
    $display("t_freeze done");
  endtask : t_freeze

  task t_iack;
    wr(OFF_CFG_LO, 8'h85);
    wr(OFF_LEVEL, 8'h03);
    wr(OFF_VECTOR, 8'h40);
    irqPending = 1'b1;
    iackLevel = 3'h3;
    tick(1);
    chk({irqLevel_q, 1'b0, arbPriority_q}, 8'h65);
    iackCycle = 1'b1;
    tick(1);
    iackCycle = 1'b0;
    chk({iackWin_q, 7'h0}, 8'h80);
    chk(iackVector_q, 8'h40);
    wr(OFF_CFG_LO, 8'h80);
    iackCycle = 1'b1;
    tick(1);
    iackCycle = 1'b0;
    chk({iackWin_q, 7'h0}, 8'h00);
    wr(OFF_LEVEL, 8'h00);
    tick(1);
    chk({5'h0, irqLevel_q}, 8'h00);
    irqPending = 1'b0;
    $display("t_iack done");
  endtask : t_iack

  task t_rts;
    portBit = 2'b01;
    tick(1);
    chk({6'h0, rtsOn_q}, 8'h01);
    portBit = 2'b00;
    tick(1);
    chk({6'h0, rtsOn_q}, 8'h00);
    wr(OFF_MODE_A, 8'h80);
    chk({7'h0, rtsOn_q[0]}, 8'h01);
    fifoFull = 2'b01;
    stnGo = 1'b1;
    tick(1);
    stnGo = 1'b0;
    tick(2);
    chk({7'h0, rtsOn_q[0]}, 8'h00);
    fifoFull = 2'b00;
    tick(1);
    chk({7'h0, rtsOn_q[0]}, 8'h01);
    txFlowEn = 2'b01;
    tick(1);
    chk({7'h0, txFlowOk_q[0]}, 8'h00);
    wr(OFF_MODE_A, 8'h00);
    tick(1);
    chk({7'h0, txFlowOk_q[0]}, 8'h01);
    txFlowEn = 2'b00;
    $display("t_rts done");
  endtask : t_rts

  task t_stat;
    wr(OFF_MODE_A, 8'h40);
    fifoFull = 2'b01;
    tick(1);
    chk({6'h0, isrRx_q}, 8'h01);
    fifoFull = 2'b00;
    tick(1);
    chk({6'h0, isrRx_q}, 8'h00);
    wr(OFF_MODE_A, 8'h20);
    rxLoad = 2'b01;
    tick(1);
    rxLoad = 2'b00;
    chk({6'h0, isrRx_q}, 8'h01);
    bufRead = 2'b01;
    fifoEmpty = 2'b01;
    tick(1);
    bufRead = 2'b00;
    chk({6'h0, isrRx_q}, 8'h00);
    topErr = 6'h04;
    topLoad = 2'b01;
    tick(1);
    topErr = 6'h01;
    tick(1);
    topLoad = 2'b00;
    topErr = 6'h00;
    otherStat[0] = 5'h05;
    rd(OFF_STAT_A, 8'ha5);
    errReset = 2'b01;
    tick(1);
    errReset = 2'b00;
    rd(OFF_STAT_A, 8'h05);
    wr(OFF_MODE_A, 8'h00);
    topErr = 6'h02;
    tick(1);
    rd(OFF_STAT_A, 8'h45);
    topErr = 6'h00;
    $display("t_stat done");
  endtask : t_stat

  task t_par;
    for (int i = 0; i < 10; i++) begin
      wr(OFF_MODE_A, PM_TAB[i]);
      tick(1);
      chk({6'h0, txParUsed_q[0], txParBit_q[0] & txParUsed_q[0]}, {6'h0, PE_TAB[i]});
    end
    wr(OFF_MODE_A, 8'h03);
    rxParIn = 2'b01;
    tick(1);
    chk({7'h0, rxParErr_q[0]}, 8'h01);
    rxParIn = 2'b00;
    tick(1);
    chk({7'h0, rxParErr_q[0]}, 8'h00);
    $display("t_par done");
  endtask : t_par

  task wrap_up;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  initial begin
    tick(5);
    rst_n = 1'b1;
    t_regs();
    t_priv();
    t_stop();
    t_swrst();
    t_freeze();
    t_iack();
    t_rts();
    t_stat();
    t_par();
    wrap_up();
  end
endmodule : tb

bind dsu_config dsu_config_asserts u_chk (.mclk(mclk), .rst_n(rst_n), .busStrobe(busStrobe),
  .busSuper(busSuper), .busAddr(busAddr), .busAck_q(busAck_q), .busErr_q(busErr_q),
  .busRdata_q(busRdata_q), .freezeReq(freezeReq), .charBoundary(charBoundary),
  .sendingBreak(sendingBreak), .chanFrozen_q(chanFrozen_q), .modClkRun_q(modClkRun_q),
  .irqPending(irqPending), .iackCycle(iackCycle), .arbPriority_q(arbPriority_q),
  .iackWin_q(iackWin_q));
